// ### hdl/rst_boot_pkg.sv
// Shared constants and types for the reset and boot clock mode block
package rst_boot_pkg;

  // Reset qualification and stretch counts, in CLK cycles
  localparam int RESET_QUALIFY_CYCLES = 8;
  localparam int RESET_STRETCH_CYCLES = 1024;
  localparam logic [3:0] QUALIFY_LAST = 4'(RESET_QUALIFY_CYCLES - 1);
  localparam logic [10:0] STRETCH_LAST = 11'(RESET_STRETCH_CYCLES - 1);

  // PLL pre-divider: the setting field holds divide ratio minus one
  localparam int PLL_PREDIV_RATIO = 6;
  localparam logic [2:0] PLL_PREDIV_RESET = 3'(PLL_PREDIV_RATIO - 1);

  // Bit positions inside the synchroniser vector
  localparam int SYNC_RESET = 0;
  localparam int SYNC_SEL0 = 1;
  localparam int SYNC_SEL1 = 2;
  localparam int SYNC_SENSE = 3;
  localparam int SYNC_FLASH_PROGRAM_MODE_REQUEST = 4;
  localparam int SYNC_TEST = 5;
  localparam int SYNC_OSC = 6;
  localparam int SYNC_W = 7;

  // Boot clock mode codes
  localparam logic [1:0] MODE_NO_PLL_EXT = 2'h0;
  localparam logic [1:0] MODE_NO_PLL_OSC_DRIVE_OUT_MODE_SENSE = 2'h1;
  localparam logic [1:0] MODE_PLL_EXT = 2'h2;
  localparam logic [1:0] MODE_PLL_OSC_DRIVE_OUT_MODE_SENSE = 2'h3;

  // Sequencer phases
  typedef enum logic [1:0]
  {
    ST_HOLD = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN = 2'b10
  } phase_type;

  // Selected system clock source
  typedef enum logic [1:0]
  {
    SRC_EXT_OSC = 2'b00,
    SRC_RELAX_OSC = 2'b01,
    SRC_CRYSTAL = 2'b10
  } clock_source_type;

  // Values after reset of the latched selections
  localparam logic RESET_PLL_ENABLE = 1'b0;
  localparam clock_source_type RESET_SOURCE = SRC_RELAX_OSC;

  // Whole state of the controller
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    phase_type phase;
    logic [3:0] qual_cnt;
    logic [10:0] stretch_cnt;
    logic cpu_reset_n;
    logic indication_n;
    logic pll_enable;
    clock_source_type source;
    logic reserved;
    logic flash_mode;
    logic sense_mode;
    logic clk_out;
    logic osc_drive_out_mode_sense_drive;
  } ctrl_state_type;

endpackage : rst_boot_pkg

// ### hdl/boot_sel_if.sv
// Carrier between the controller and the boot clock mode decoder
`timescale 1ns/10ps
interface boot_sel_if;
  import rst_boot_pkg::*;
  logic [1:0] boot_clock_select; // Synchronised mode pins
  logic sense; // Synchronised crystal pin level
  logic pll_enable; // Decoded PLL enable
  clock_source_type source; // Decoded clock source
  logic reserved; // Decoded code is reserved

  modport decoder
  (
    input boot_clock_select,
    input sense,
    output pll_enable,
    output source,
    output reserved
  );

  modport control
  (
    output boot_clock_select,
    output sense,
    input pll_enable,
    input source,
    input reserved
  );
endinterface : boot_sel_if

// ### hdl/boot_mode_decode.sv
// Combinational decoder from boot clock mode pins to PLL and source choice
`timescale 1ns/10ps
module boot_mode_decode
  import rst_boot_pkg::*;
(
  boot_sel_if.decoder sel
);

  // Table decode; the crystal pin only matters when the low select bit is 0
  always_comb
  begin
    sel.pll_enable = 1'b0;
    sel.source = SRC_EXT_OSC;
    sel.reserved = 1'b0;
    case (sel.boot_clock_select)
      MODE_NO_PLL_EXT:
      begin
        // Pin low picks the external oscillator, high the on-chip one
        sel.source = sel.sense ? SRC_RELAX_OSC : SRC_EXT_OSC; // R4
      end
      MODE_NO_PLL_OSC_DRIVE_OUT_MODE_SENSE:
      begin
        sel.source = SRC_CRYSTAL; // R5
      end
      MODE_PLL_EXT:
      begin
        if (!sel.sense)
        begin
          sel.pll_enable = 1'b1; // R6
          sel.source = SRC_EXT_OSC;
        end
        else
        begin
          // Reserved: would mean relaxation oscillator with PLL, never offered
          sel.reserved = 1'b1; // R9
          sel.source = SRC_EXT_OSC;
        end
      end
      default:
      begin
        sel.pll_enable = 1'b1; // R7
        sel.source = SRC_CRYSTAL;
      end
    endcase
  end

endmodule : boot_mode_decode

// ### hdl/reset_boot_ctrl.sv
// Reset qualification, reset stretch and boot clock configuration latch
`timescale 1ns/10ps

// How it works
// R1 - Eight low cycles on reset pin reset all
// R2 - Reset indication low 1024 clocks after release
// R3 - Low select bit zero: crystal pin is sensed
// R4 - Code 00: no PLL, pin picks source
// R5 - Code 01: no PLL, crystal, pin ignored
// R6 - Code 10, pin 0: PLL on external oscillator
// R7 - Code 11: PLL on crystal, pin ignored
// R8 - PLL pre-divider resets to six
// R9 - Never relaxation oscillator together with PLL
// R10 - Request high, test low at release: programming
// R11 - Board keeps factory test pin grounded
// R12 - Clock output follows internal system clock
// R13 - Oscillator input used unless relaxation selected
// R14 - Pins latched at release, held until reset
module reset_boot_ctrl
  import rst_boot_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic RESET_INPUT_N,
  input wire logic [1:0] BOOT_CLOCK_SELECT,
  input wire logic OSC_CLOCK_IN,
  input wire logic OSC_DRIVE_OUT_MODE_SENSE_I,
  output logic OSC_DRIVE_OUT_MODE_SENSE_O,
  output logic OSC_DRIVE_OUT_MODE_SENSE_OE,
  input wire logic FLASH_PROGRAM_MODE_REQUEST,
  input wire logic FACTORY_TEST,
  output logic RESET_INDICATION_N,
  output logic CPU_RESET_N,
  output logic SYSTEM_CLOCK_OUT,
  output logic PLL_ENABLE,
  output logic [1:0] CLOCK_SOURCE,
  output logic CLOCK_MODE_RESERVED,
  output logic OSC_INPUT_ENABLE,
  output logic [2:0] PLL_PREDIVIDER_SETTING,
  output logic FLASH_PROGRAM_MODE
);

  // Registered state and its next value
  ctrl_state_type state;
  ctrl_state_type next_state;

  // Raw pin vector before synchronisation
  logic [SYNC_W-1:0] pins;

  // Synchronised views, all taken from the second stage
  logic pin_reset_low; // Reset pin seen low this cycle
  logic reset_qualified; // Eighth consecutive low cycle
  logic release_now; // Reset source just went away

  // Decoder carrier
  boot_sel_if sel ();

  // Decoder of the latched-to-be mode pins
  boot_mode_decode u_decode
  (
    .sel(sel.decoder)
  );

  // Gather every asynchronous pin so one synchroniser serves them all
  always_comb
  begin
    pins = '0;
    pins[SYNC_RESET] = RESET_INPUT_N;
    pins[SYNC_SEL0] = BOOT_CLOCK_SELECT[0];
    pins[SYNC_SEL1] = BOOT_CLOCK_SELECT[1];
    pins[SYNC_SENSE] = OSC_DRIVE_OUT_MODE_SENSE_I;
    pins[SYNC_FLASH_PROGRAM_MODE_REQUEST] = FLASH_PROGRAM_MODE_REQUEST;
    pins[SYNC_TEST] = FACTORY_TEST;
    pins[SYNC_OSC] = OSC_CLOCK_IN;
  end

  // Decoder sees only second-stage values
  always_comb
  begin
    sel.boot_clock_select = {state.sync2[SYNC_SEL1], state.sync2[SYNC_SEL0]};
    sel.sense = state.sync2[SYNC_SENSE]; // R3
  end

  // Reset pin qualification terms
  always_comb
  begin
    pin_reset_low = !state.sync2[SYNC_RESET];
    // A short glitch never resets; the eighth low cycle does at once
    reset_qualified = pin_reset_low && (state.qual_cnt == QUALIFY_LAST); // R1
    // In hold, the source is gone when the pin reads high again
    release_now = (state.phase == ST_HOLD) && !pin_reset_low;
  end

  // Next-state logic for the whole controller
  always_comb
  begin
    next_state = state;

    // Two-stage synchroniser; stage one feeds stage two only
    next_state.sync1 = pins;
    next_state.sync2 = state.sync1;

    // Consecutive low-cycle counter, saturating below the threshold
    if (!pin_reset_low)
    begin
      next_state.qual_cnt = '0;
    end
    else if (state.qual_cnt != QUALIFY_LAST)
    begin
      next_state.qual_cnt = state.qual_cnt + 4'h1;
    end

    // Free toggle standing in for the system clock on the output pin
    next_state.clk_out = !state.clk_out; // R12

    // Inverting amplifier stand-in for the crystal drive
    next_state.osc_drive_out_mode_sense_drive = !state.sync2[SYNC_OSC];

    case (state.phase)
      ST_HOLD:
      begin
        // Everything held in reset while the source stays active
        next_state.cpu_reset_n = 1'b0; // R1
        next_state.indication_n = 1'b0;
        next_state.stretch_cnt = '0;
        if (release_now)
        begin
          // Capture configuration exactly once, as the source goes away
          next_state.pll_enable = sel.pll_enable; // R14
          next_state.source = sel.source; // R14
          next_state.reserved = sel.reserved; // R9
          next_state.sense_mode = !state.sync2[SYNC_SEL0]; // R3
          // Programming mode needs the test pin low at the same moment
          next_state.flash_mode = state.sync2[SYNC_FLASH_PROGRAM_MODE_REQUEST] && !state.sync2[SYNC_TEST]; // R10
          next_state.cpu_reset_n = 1'b1;
          next_state.phase = ST_STRETCH;
        end
      end
      ST_STRETCH:
      begin
        if (reset_qualified)
        begin
          // A fresh reset restarts everything from hold
          next_state.cpu_reset_n = 1'b0; // R1
          next_state.phase = ST_HOLD;
        end
        else if (state.stretch_cnt == STRETCH_LAST)
        begin
          // Indication has been low for the full stretch
          next_state.indication_n = 1'b1; // R2
          next_state.phase = ST_RUN;
        end
        else
        begin
          next_state.stretch_cnt = state.stretch_cnt + 11'h001; // R2
        end
      end
      ST_RUN:
      begin
        if (reset_qualified)
        begin
          // Immediate reset of CPU and peripherals
          next_state.cpu_reset_n = 1'b0; // R1
          next_state.indication_n = 1'b0;
          next_state.phase = ST_HOLD;
        end
      end
      default:
      begin
        // Unused code: fall back into hold for safety
        next_state.phase = ST_HOLD;
      end
    endcase
  end

  // State register; asynchronous reset loads constants only
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state.sync1 <= '0;
      state.sync2 <= '0;
      state.phase <= ST_HOLD;
      state.qual_cnt <= '0;
      state.stretch_cnt <= '0;
      state.cpu_reset_n <= 1'b0;
      state.indication_n <= 1'b0;
      state.pll_enable <= RESET_PLL_ENABLE;
      state.source <= RESET_SOURCE;
      state.reserved <= 1'b0;
      state.flash_mode <= 1'b0;
      // Start in sense mode so the crystal pin is not driven before the latch
      state.sense_mode <= 1'b1;
      state.clk_out <= 1'b0;
      state.osc_drive_out_mode_sense_drive <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Output mapping; outputs come straight from flip-flops, except the constant pre-divider and the two decoded enables
  always_comb
  begin
    CPU_RESET_N = state.cpu_reset_n; // R1
    RESET_INDICATION_N = state.indication_n; // R2
    SYSTEM_CLOCK_OUT = state.clk_out; // R12
    PLL_ENABLE = state.pll_enable;
    CLOCK_SOURCE = state.source;
    CLOCK_MODE_RESERVED = state.reserved;
    FLASH_PROGRAM_MODE = state.flash_mode; // R10
    // Pre-divider is held at its fixed reset value; nothing here changes it
    PLL_PREDIVIDER_SETTING = PLL_PREDIV_RESET; // R8
    // Oscillator input is idle only when the relaxation oscillator runs
    OSC_INPUT_ENABLE = (state.source != SRC_RELAX_OSC); // R13
    OSC_DRIVE_OUT_MODE_SENSE_O = state.osc_drive_out_mode_sense_drive;
    // Never drive the crystal pin in hold or while it is a sense input
    OSC_DRIVE_OUT_MODE_SENSE_OE = (state.phase != ST_HOLD) && !state.sense_mode; // R3
  end

endmodule : reset_boot_ctrl

// ### sim/reset_boot_chk.sv
// Port checks for the reset and boot clock mode controller
`timescale 1ns/10ps
module reset_boot_chk
  import rst_boot_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic RESET_INPUT_N,
  input wire logic [1:0] BOOT_CLOCK_SELECT,
  input wire logic OSC_CLOCK_IN,
  input wire logic OSC_DRIVE_OUT_MODE_SENSE_O,
  input wire logic FLASH_PROGRAM_MODE_REQUEST,
  input wire logic FACTORY_TEST,
  input wire logic OSC_DRIVE_OUT_MODE_SENSE_OE,
  input wire logic RESET_INDICATION_N,
  input wire logic CPU_RESET_N,
  input wire logic SYSTEM_CLOCK_OUT,
  input wire logic PLL_ENABLE,
  input wire logic [1:0] CLOCK_SOURCE,
  input wire logic OSC_INPUT_ENABLE,
  input wire logic [2:0] PLL_PREDIVIDER_SETTING,
  input wire logic FLASH_PROGRAM_MODE
);
  logic [3:0] low_cnt; // Consecutive low pin samples, saturating
  logic [10:0] hold_cnt; // Stretch cycles since the CPU left reset
  // Counters, so long spans need no long repetition
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      low_cnt <= 4'h0;
      hold_cnt <= 11'h000;
    end
    else
    begin
      low_cnt <= RESET_INPUT_N ? 4'h0 : (low_cnt == 4'hF ? low_cnt : low_cnt + 4'h1);
      hold_cnt <= !CPU_RESET_N ? 11'h000 : hold_cnt + 11'(!RESET_INDICATION_N);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Pin may already be high again when the CPU reset lands, so look back past the synchroniser
  a_qualify_min: assert property ($fell(CPU_RESET_N) |-> $past(low_cnt, 2) >= 4'h8)
    else $error("CPU reset on a short pulse");
  a_stretch_len: assert property ($rose(RESET_INDICATION_N) |-> hold_cnt == 11'h400)
    else $error("Reset indication stretch length wrong");
  a_sense_drive: assert property ($rose(CPU_RESET_N) |-> OSC_DRIVE_OUT_MODE_SENSE_OE == BOOT_CLOCK_SELECT[0])
    else $error("Crystal pin drive wrong for select");
  a_flash_entry: assert property ($rose(CPU_RESET_N) |-> FLASH_PROGRAM_MODE == (FLASH_PROGRAM_MODE_REQUEST && !FACTORY_TEST))
    else $error("Programming mode entry wrong");
  a_cfg_held: assert property (CPU_RESET_N && $past(CPU_RESET_N) |-> $stable({PLL_ENABLE, CLOCK_SOURCE, FLASH_PROGRAM_MODE}))
    else $error("Boot selection changed while running");
  a_no_relax_pll: assert property (!(PLL_ENABLE && CLOCK_SOURCE == 2'h1))
    else $error("PLL on relaxation oscillator");
  a_osc_input: assert property (OSC_INPUT_ENABLE == (CLOCK_SOURCE != 2'h1))
    else $error("Oscillator input enable wrong");
  a_prediv_fixed: assert property (PLL_PREDIVIDER_SETTING == PLL_PREDIV_RESET)
    else $error("Pre-divider setting wrong");
  a_clock_toggle: assert property ($past(NRST) |-> SYSTEM_CLOCK_OUT != $past(SYSTEM_CLOCK_OUT))
    else $error("Clock output stopped");
  // Drive value is the inverted oscillator, two synchroniser stages plus one register late
  a_osc_drive_out_mode_sense_drive: assert property ($past(NRST, 3) |-> OSC_DRIVE_OUT_MODE_SENSE_O == !$past(OSC_CLOCK_IN, 3))
    else $error("Crystal drive does not follow oscillator");
  c_stretch: cover property ($rose(RESET_INDICATION_N));
  c_pin_reset: cover property ($fell(CPU_RESET_N));
  c_pll_boot: cover property ($rose(CPU_RESET_N) && PLL_ENABLE);
endmodule : reset_boot_chk
bind reset_boot_ctrl reset_boot_chk u_reset_boot_chk (.CLK, .NRST, .RESET_INPUT_N, .BOOT_CLOCK_SELECT,
  .OSC_CLOCK_IN, .OSC_DRIVE_OUT_MODE_SENSE_O,
  .FLASH_PROGRAM_MODE_REQUEST, .FACTORY_TEST, .OSC_DRIVE_OUT_MODE_SENSE_OE, .RESET_INDICATION_N, .CPU_RESET_N,
  .SYSTEM_CLOCK_OUT, .PLL_ENABLE, .CLOCK_SOURCE, .OSC_INPUT_ENABLE, .PLL_PREDIVIDER_SETTING, .FLASH_PROGRAM_MODE);

// ### sim/board_model.sv
// Board side: reset button, straps and oscillator
`timescale 1ns/10ps
module board_model
(
  input wire logic press, // Reset button held
  input wire logic sns, // Strap level on the crystal pin
  input wire logic t_in, // Factory test strap
  input wire logic xo, // Device drive value
  input wire logic xoe, // Device drive enable
  output logic rst_n, // Reset pin
  output logic xl, // Resolved crystal pin
  output logic osc, // Oscillator
  output logic test // Factory test pin
);
  // Free-running oscillator, unrelated to CLK; one tick of offset keeps its edges off every CLK edge
  initial
  begin
    osc = 1'b0;
    #0.01;
    forever #7.3 osc = ~osc;
  end
  assign rst_n = ~press;
  assign test = t_in;
  // Device drive wins, else the strap resistor sets the level
  assign xl = xoe ? xo : sns;
endmodule : board_model

// ### sim/reset_and_boot_clock_mode_test.sv
// Self-checking bench for the reset and boot clock mode controller
`timescale 1ns/10ps
module reset_and_boot_clock_mode_test;
  import rst_boot_pkg::*;
  logic clk = 1'b0; // 200 MHz
  logic nrst = 1'b0; // Power-on reset
  logic press = 1'b0; // Reset button
  logic sense = 1'b0; // Crystal pin strap
  logic prog = 1'b0; // Programmer request
  logic tst = 1'b0; // Test strap, grounded normally
  logic [1:0] strap = 2'h0; // Mode straps
  logic rst_n, xl, osc, test, xo, xoe, ind_n, cpu_n, sco, pll, res, oie, fpm;
  logic [1:0] src;
  logic [2:0] pdiv;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  // Straps {select, crystal pin} and expected {PLL, source, reserved}
  logic [2:0] m_in [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [3:0] m_exp [6] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h1, 4'hC};
  board_model u_board_model (.press, .sns(sense), .t_in(tst), .xo, .xoe, .rst_n, .xl, .osc, .test);
  reset_boot_ctrl u_reset_boot_ctrl (.CLK(clk), .NRST(nrst), .RESET_INPUT_N(rst_n), .BOOT_CLOCK_SELECT(strap),
    .OSC_CLOCK_IN(osc), .OSC_DRIVE_OUT_MODE_SENSE_I(xl), .OSC_DRIVE_OUT_MODE_SENSE_O(xo),
    .OSC_DRIVE_OUT_MODE_SENSE_OE(xoe), .FLASH_PROGRAM_MODE_REQUEST(prog), .FACTORY_TEST(test),
    .RESET_INDICATION_N(ind_n), .CPU_RESET_N(cpu_n), .SYSTEM_CLOCK_OUT(sco), .PLL_ENABLE(pll),
    .CLOCK_SOURCE(src), .CLOCK_MODE_RESERVED(res), .OSC_INPUT_ENABLE(oie),
    .PLL_PREDIVIDER_SETTING(pdiv), .FLASH_PROGRAM_MODE(fpm));
  always #2.5 clk = ~clk;
  task check(input string what, input logic [10:0] exp, input logic [10:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Power-on reset with straps set well before release
  task boot(input logic [2:0] pins, input logic p, input logic t);
    @(negedge clk);
    nrst = 1'b0;
    {strap, sense} = pins;
    prog = p;
    tst = t;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
  endtask : boot
  // Every boot code; straps flipped afterwards must not matter
  task modes;
    for (int i = 0; i < 6; i++)
    begin
      boot(m_in[i], 1'b0, 1'b0);
      check("mode", 11'(m_exp[i]), 11'({pll, src, res}));
      check("osc in", 11'(m_exp[i][2:1] != 2'h1), 11'(oie));
      check("osc_drive_out_mode_sense oe", 11'(m_in[i][1]), 11'(xoe));
      {strap, sense} = ~m_in[i];
      repeat (3) @(negedge clk);
      check("held", 11'(m_exp[i]), 11'({pll, src, res}));
    end
  endtask : modes
  // Programming entry, hold after release, and test pin veto
  task flash;
    boot(3'h0, 1'b1, 1'b0);
    check("flash", 11'h1, 11'(fpm));
    prog = 1'b0;
    repeat (3) @(negedge clk);
    check("flash held", 11'h1, 11'(fpm));
    boot(3'h0, 1'b1, 1'b1);
    check("flash test", 11'h0, 11'(fpm));
  endtask : flash
  // Seven-cycle press ignored, long press resets, stretch timed
  task pulse;
    boot(3'h7, 1'b0, 1'b0);
    press = 1'b1;
    repeat (7) @(negedge clk);
    press = 1'b0;
    repeat (12) @(negedge clk);
    check("short pulse", 11'h1, 11'(cpu_n));
    press = 1'b1;
    repeat (12) @(negedge clk);
    check("long pulse", 11'h0, 11'({cpu_n, ind_n}));
    press = 1'b0;
    n = 0;
    while (cpu_n !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check("release", 11'h3, 11'(n));
    n = 0;
    while (ind_n !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    check("stretch", 11'h400, 11'(n));
  endtask : pulse
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Main sequence, starting inside the power-on reset
  initial
  begin
    repeat (8) @(negedge clk);
    check("reset", 11'h010, 11'({pll, src, res, fpm, cpu_n, ind_n}));
    check("prediv", 11'(PLL_PREDIV_RATIO - 1), 11'(pdiv));
    modes;
    flash;
    pulse;
    finish_test;
  end
  // Run is near 1200 cycles; 60 us is ample margin
  initial
  begin
    #60000;
    error_cnt++;
    finish_test;
  end
endmodule : reset_and_boot_clock_mode_test
